// File: inc/brp_defs.svh
`ifndef BRP_DEFS_SVH
`define BRP_DEFS_SVH

`define BRP_WORD_W 32
`define BRP_LANE_W 8
`define BRP_PAR_ODD 1'b1
`define BRP_RST_WORD 32'h0000_0000

`endif

// File: inc/brp_pkg.sv
package brp_pkg;

    // rotation amount, left-end around, in byte steps
    typedef enum logic [1:0] {
        BRP_ROT_0  = 2'h0,
        BRP_ROT_8  = 2'h1,
        BRP_ROT_16 = 2'h2,
        BRP_ROT_24 = 2'h3
    } brp_rot_t;

    // direction of the transfer through the stage
    typedef enum logic [2:0] {
        BRP_DIR_IDLE  = 3'b001,
        BRP_DIR_READ  = 3'b010,
        BRP_DIR_WRITE = 3'b100
    } brp_dir_t;

endpackage : brp_pkg

// File: src/brp_rotator.sv
`timescale 1ns/1ps
`include "brp_defs.svh"

// Notes on behaviour
// - every outgoing bus word passes this stage; no bypass path exists
// - rotate the 32-bit word left-end around by 0, 8, 16 or 24 bits
// - rotation amount comes with each transfer from the moving instruction
// - check parity of every word read from control memory
// - generate a parity bit for every word written to control memory
// - bit 0 is leftmost and most significant; left rotation lowers bit numbers
// - four byte lanes, lane 0 is bits 0-7; high half is bits 0-15
module brp_rotator
    import brp_pkg::*;
#(
    parameter int WORD_W = `BRP_WORD_W,
    parameter int LANE_W = `BRP_LANE_W,
    parameter logic PARITY_ODD = `BRP_PAR_ODD
)
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic xfer_valid_in,
    input wire logic xfer_read_in,
    input wire logic [1:0] rot_sel_in,
    input wire logic [WORD_W-1:0] bus_word_in,
    input wire logic mem_parity_in,
    output logic xfer_valid_out,
    output logic xfer_read_out,
    output logic [WORD_W-1:0] bus_word_out,
    output logic mem_parity_out,
    output logic parity_error_out,
    output logic [LANE_W-1:0] shared_word_lane0_out,
    output logic [LANE_W-1:0] shared_word_lane3_out,
    output logic [2*LANE_W-1:0] shared_word_upper_half_out,
    output logic [2*LANE_W-1:0] shared_word_lower_half_out
);

    ////////////////////////////////////////////////////////////////////////////
    // bit 0 of the documented numbering is the vector msb [WORD_W-1]
    function automatic logic [WORD_W-1:0] rot_left(input logic [WORD_W-1:0] w,
                                                   input brp_rot_t r);
        logic [WORD_W-1:0] res;
        res = w;
        unique case (r)
            BRP_ROT_0:  res = w;
            BRP_ROT_8:  res = {w[WORD_W-LANE_W-1:0], w[WORD_W-1 -: LANE_W]};
            BRP_ROT_16: res = {w[WORD_W-2*LANE_W-1:0], w[WORD_W-1 -: 2*LANE_W]};
            BRP_ROT_24: res = {w[LANE_W-1:0], w[WORD_W-1 -: WORD_W-LANE_W]};
        endcase
        return res;
    endfunction : rot_left

    function automatic logic par_of(input logic [WORD_W-1:0] w);
        return (^w) ^ PARITY_ODD;
    endfunction : par_of

    ////////////////////////////////////////////////////////////////////////////
    logic [WORD_W-1:0] rot_word;
    logic par_bad;
    brp_dir_t dir_r;

    assign rot_word = rot_left(bus_word_in, brp_rot_t'(rot_sel_in));
    assign par_bad = xfer_valid_in && xfer_read_in && (par_of(bus_word_in) != mem_parity_in);

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            bus_word_out <= `BRP_RST_WORD;
            xfer_valid_out <= 1'b0;
            xfer_read_out <= 1'b0;
        end
        else
        begin
            bus_word_out <= xfer_valid_in ? rot_word : bus_word_out;
            xfer_valid_out <= xfer_valid_in;
            xfer_read_out <= xfer_valid_in & xfer_read_in;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            dir_r <= BRP_DIR_IDLE;
        else if (!xfer_valid_in)
            dir_r <= BRP_DIR_IDLE;
        else if (xfer_read_in)
            dir_r <= BRP_DIR_READ;
        else
            dir_r <= BRP_DIR_WRITE;
    end

    // write parity is taken over the word as it is stored, after rotation
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            mem_parity_out <= 1'b0;
        else if (xfer_valid_in && !xfer_read_in)
            mem_parity_out <= par_of(rot_word);
    end

    // one-cycle pulse per bad read word
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            parity_error_out <= 1'b0;
        else
            parity_error_out <= par_bad;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            shared_word_lane0_out <= '0;
            shared_word_lane3_out <= '0;
            shared_word_upper_half_out <= '0;
            shared_word_lower_half_out <= '0;
        end
        else if (xfer_valid_in)
        begin
            shared_word_lane0_out <= rot_word[WORD_W-1 -: LANE_W];
            shared_word_lane3_out <= rot_word[LANE_W-1:0];
            shared_word_upper_half_out <= rot_word[WORD_W-1 -: 2*LANE_W];
            shared_word_lower_half_out <= rot_word[2*LANE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_rot_value;
        @(posedge clock_in) disable iff (reset_in)
        xfer_valid_in |=>
            bus_word_out == rot_left($past(bus_word_in), brp_rot_t'($past(rot_sel_in)));
    endproperty
    a_rot_value: assert property (p_rot_value) else $error("rotated word wrong");

    property p_rot16_halves;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && rot_sel_in == 2'h2) |=>
            shared_word_upper_half_out == $past(bus_word_in[2*LANE_W-1:0]);
    endproperty
    a_rot16_halves: assert property (p_rot16_halves) else $error("half swap wrong");

    property p_rot8_lane;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && rot_sel_in == 2'h1) |=>
            shared_word_lane3_out == $past(bus_word_in[WORD_W-1 -: LANE_W]);
    endproperty
    a_rot8_lane: assert property (p_rot8_lane) else $error("lane 0 did not wrap");

    property p_rot_zero;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && rot_sel_in == 2'h0) |=> bus_word_out == $past(bus_word_in);
    endproperty
    a_rot_zero: assert property (p_rot_zero) else $error("zero rotation altered word");

    property p_hold;
        @(posedge clock_in) disable iff (reset_in)
        !xfer_valid_in |=> $stable(bus_word_out) && !xfer_valid_out;
    endproperty
    a_hold: assert property (p_hold) else $error("word changed when idle");

    property p_wr_parity;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && !xfer_read_in) |=>
            ((^bus_word_out) ^ mem_parity_out) == PARITY_ODD;
    endproperty
    a_wr_parity: assert property (p_wr_parity) else $error("write parity wrong");

    property p_rd_err;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && xfer_read_in && ((^bus_word_in) ^ mem_parity_in) != PARITY_ODD)
            |=> parity_error_out && xfer_read_out;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("parity error missed");

    property p_no_false_err;
        @(posedge clock_in) disable iff (reset_in)
        (!xfer_valid_in || !xfer_read_in) |=> !parity_error_out;
    endproperty
    a_no_false_err: assert property (p_no_false_err) else $error("spurious parity error");

    property p_valid_pulse;
        @(posedge clock_in) disable iff (reset_in)
        xfer_valid_in |=> xfer_valid_out;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("accepted word not shown");

    property p_rot24_lane;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && rot_sel_in == 2'h3) |=>
            shared_word_lane0_out == $past(bus_word_in[LANE_W-1:0]);
    endproperty
    a_rot24_lane: assert property (p_rot24_lane) else $error("lane 3 not in lane 0");

    property p_rot16_lower;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && rot_sel_in == 2'h2) |=>
            shared_word_lower_half_out == $past(bus_word_in[WORD_W-1 -: 2*LANE_W]);
    endproperty
    a_rot16_lower: assert property (p_rot16_lower) else $error("low half swap wrong");

    property p_slices_hold;
        @(posedge clock_in) disable iff (reset_in)
        !xfer_valid_in |=> $stable(shared_word_upper_half_out) &&
            $stable(shared_word_lower_half_out) && $stable(shared_word_lane0_out) &&
            $stable(shared_word_lane3_out);
    endproperty
    a_slices_hold: assert property (p_slices_hold) else $error("slices changed when idle");

    property p_rd_keeps_parity;
        @(posedge clock_in) disable iff (reset_in)
        (xfer_valid_in && xfer_read_in) |=> $stable(mem_parity_out);
    endproperty
    a_rd_keeps_parity: assert property (p_rd_keeps_parity) else $error("read moved parity");

    property p_err_on_read;
        @(posedge clock_in) disable iff (reset_in)
        parity_error_out |-> xfer_read_out;
    endproperty
    a_err_on_read: assert property (p_err_on_read) else $error("error without read");

    // the direction register must agree with the shown flags
    property p_dir_track;
        @(posedge clock_in) disable iff (reset_in)
        ((dir_r == BRP_DIR_READ) == xfer_read_out) &&
            ((dir_r == BRP_DIR_IDLE) == !xfer_valid_out);
    endproperty
    a_dir_track: assert property (p_dir_track) else $error("direction out of step");

    property p_reset_clear;
        @(posedge clock_in)
        reset_in |=> !xfer_valid_out && !xfer_read_out && !parity_error_out &&
            !mem_parity_out && bus_word_out == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");

endmodule : brp_rotator

// File: dv/brp_mem_model.sv
`timescale 1ns/1ps
// control memory side: returns the stored parity bit, corrupted on request
module brp_mem_model
(
    input wire logic [31:0] word_in,
    input wire logic corrupt_in,
    output logic parity_out
);
    assign parity_out = ~(^word_in) ^ corrupt_in;
endmodule : brp_mem_model

// File: dv/brp_rotator_test.sv
`timescale 1ns/1ps
`include "brp_defs.svh"
module brp_rotator_test;
    import brp_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic valid = 1'b0;
    logic rd = 1'b0;
    logic bad = 1'b0;
    logic [1:0] rot = 2'h0;
    logic [31:0] word = 32'h0;
    logic [31:0] e_word = 32'h0;
    logic [31:0] wo;
    logic mpar, vo, ro, po, eo;
    logic e_par = 1'b0;
    logic e_v = 1'b0;
    logic e_r = 1'b0;
    logic e_err = 1'b0;
    logic [7:0] l0, l3;
    logic [15:0] uh, lh;
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 32'hB08F;
    int r;
    initial forever #10 clock_in = ~clock_in;
    brp_mem_model u_mem (.word_in(word), .corrupt_in(bad), .parity_out(mpar));
    brp_rotator u_dut (.clock_in(clock_in), .reset_in(reset_in), .xfer_valid_in(valid),
        .xfer_read_in(rd), .rot_sel_in(rot), .bus_word_in(word), .mem_parity_in(mpar),
        .xfer_valid_out(vo), .xfer_read_out(ro), .bus_word_out(wo), .mem_parity_out(po),
        .parity_error_out(eo), .shared_word_lane0_out(l0), .shared_word_lane3_out(l3),
        .shared_word_upper_half_out(uh), .shared_word_lower_half_out(lh));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // byte lanes in a queue, lane 0 first; each step moves the front lane to the back
    function automatic logic [31:0] model_rot(input logic [31:0] w, input int n);
        logic [7:0] lanes[$];
        lanes = {w[31:24], w[23:16], w[15:8], w[7:0]};
        for (int k = 0; k < n; k++)
            lanes.push_back(lanes.pop_front());
        return {lanes[0], lanes[1], lanes[2], lanes[3]};
    endfunction : model_rot
    function automatic logic model_par(input logic [31:0] w);
        int ones;
        ones = $countones(w);
        return ((ones % 2) != 0) ^ `BRP_PAR_ODD;
    endfunction : model_par
    task automatic results();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        for (int i = 0; i < 400; i++)
        begin
            chk_bit(vo, e_v);
            chk_bit(ro, e_r);
            chk_bit(eo, e_err);
            chk_word(wo, e_word);
            chk_bit(po, e_par);
            chk_word({l0, l3, uh}, {e_word[31:24], e_word[7:0], e_word[31:16]});
            chk_word({16'h0000, lh}, {16'h0000, e_word[15:0]});
            // second reset mid-run, with requests still offered while it is held;
            // the first edge after each release stays idle
            reset_in = i >= 200 && i <= 202;
            r = $random(seed);
            valid = i != 0 && i != 203 && (i < 9 || r[4]);
            rd = i < 9 ? i[2] : r[0];
            rot = i < 9 ? i[1:0] : r[2:1];
            bad = i < 9 ? i == 6 : r[3];
            word = i == 1 ? 32'h1234_5678 : $random(seed);
            if (reset_in)
            begin
                e_v = 1'b0;
                e_r = 1'b0;
                e_err = 1'b0;
                e_word = 32'h0000_0000;
                e_par = 1'b0;
            end
            else
            begin
                e_v = valid;
                e_r = valid && rd;
                e_err = valid && rd && bad;
                if (valid)
                    e_word = model_rot(word, rot);
                if (valid && !rd)
                    e_par = model_par(e_word);
            end
            @(negedge clock_in);
        end
        results();
    end
endmodule : brp_rotator_test
